/* hdl/oemlh_consts.vh */
// constants for the oam endpoint mapping and loss-measurement hierarchy
// assumes inclusion by hdl/oemlh_top.v and by the monitor and bench testbench files; definitions, no logic
`ifndef OEMLH_CONSTS_VH
`define OEMLH_CONSTS_VH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define OEMLH_EP_W        4
`define OEMLH_NUM_EP      16
`define OEMLH_SVC_W       4
`define OEMLH_NUM_SVC     16
`define OEMLH_PORT_W      3
`define OEMLH_NUM_PORT    4'h6
`define OEMLH_CNT_W       16
`define OEMLH_INC_W       3
`define OEMLH_ADDR_W      12
`define OEMLH_MEMBERS     6

// ----------------------------------------------------------------------
// register blocks, selected by paddr[11:8], entry by paddr[5:2]
// ----------------------------------------------------------------------
`define OEMLH_BLK_CTRL    4'h1
`define OEMLH_BLK_LINK    4'h2
`define OEMLH_BLK_SVC     4'h3
`define OEMLH_BLK_CNT     4'h4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define OEMLH_CTRL_ENA    0
`define OEMLH_CTRL_UP     1
`define OEMLH_CTRL_SRV    2
`define OEMLH_CTRL_PORT   4
`define OEMLH_LINK_ENA    0
`define OEMLH_LINK_ID     4
`define OEMLH_SVC_ENA     0
`define OEMLH_SVC_IDX     4
`define OEMLH_CNT_TX      16

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define OEMLH_RST_FLAGS   16'h0000
`define OEMLH_RST_PORT    3'h0
`define OEMLH_RST_IDX     4'h0
`define OEMLH_RST_CNT     16'h0000

`endif

/* hdl/oemlh_top.v */
// oam endpoint mapping: one active endpoint per lookup stage, fan-out of
// loss-measurement counts over service, server and port endpoints
// assumes analyzer and rewriter stages present one frame lookup per cycle
// each, synchronous to pclk; configuration reached over apb
//
// Operation
// - up-facing transmit lookup happens at the analyzer on ingress frames
// - up-facing receive lookup happens at the rewriter on egress frames
// - down-facing transmit lookup at rewriter, receive lookup at analyzer
// - up-facing own transmit oam enters ingress; receive taken from egress
// - analyzer uses service table entry index only when its enable is one
// - rewriter uses classifier action index only when its valid flag is one
// - unmapped frames go to their port endpoint, always looked up
// - disabled selected endpoint means no processing of the frame
// - frame on a port endpoint counts in that port endpoint only
// - service frame counts in service, resident port, optionally one server
// - three-level counting works at both analyzer and rewriter stages
// - one lookup per stage, active endpoint updates all member counters
// - user-to-network: analyzer tx gives up-facing, rewriter tx down-facing
// - network-to-user: analyzer rx gives down-facing, rewriter rx up-facing
// - active down service counts itself, its server and network port
// - active down server counts itself and the network port endpoint
// - active up service counts itself, its up server and user port
// - active up server counts only itself, user port untouched
// - up to six counting levels across both stages of one flow
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "oemlh_consts.vh"

module oemlh_top (
  input  wire                        pclk,
  input  wire                        presetn,
  input  wire                        psel,
  input  wire                        penable,
  input  wire                        pwrite,
  input  wire [`OEMLH_ADDR_W-1:0]    paddr,
  input  wire [31:0]                 pwdata,
  output reg  [31:0]                 prdata,
  output wire                        pready,
  output reg                         pslverr,
  input  wire                        ana_valid,
  input  wire [`OEMLH_PORT_W-1:0]    ana_port,
  input  wire [`OEMLH_SVC_W-1:0]     ana_service_index,
  input  wire                        rew_valid,
  input  wire [`OEMLH_PORT_W-1:0]    rew_port,
  input  wire                        egress_endpoint_map_valid,
  input  wire [`OEMLH_EP_W-1:0]      egress_endpoint_index,
  output reg                         ana_active_valid,
  output reg  [`OEMLH_EP_W-1:0]      ana_active_ep,
  output reg                         ana_active_tx,
  output reg                         rew_active_valid,
  output reg  [`OEMLH_EP_W-1:0]      rew_active_ep,
  output reg                         rew_active_tx
);

  // --------------------------------------------------------------------
  // configuration and counter storage
  // --------------------------------------------------------------------
  reg  [`OEMLH_NUM_EP-1:0]   ep_ena_q;
  reg  [`OEMLH_NUM_EP-1:0]   ep_up_q;
  reg  [`OEMLH_NUM_EP-1:0]   ep_srv_q;
  reg  [`OEMLH_PORT_W-1:0]   ep_port_q   [0:`OEMLH_NUM_EP-1];
  reg  [`OEMLH_NUM_EP-1:0]   link_ena_q;
  reg  [`OEMLH_EP_W-1:0]     link_id_q   [0:`OEMLH_NUM_EP-1];
  reg  [`OEMLH_NUM_SVC-1:0]  svc_ena_q;
  reg  [`OEMLH_EP_W-1:0]     svc_idx_q   [0:`OEMLH_NUM_SVC-1];
  reg  [`OEMLH_CNT_W-1:0]    cnt_rx_q    [0:`OEMLH_NUM_EP-1];
  reg  [`OEMLH_CNT_W-1:0]    cnt_tx_q    [0:`OEMLH_NUM_EP-1];

  // --------------------------------------------------------------------
  // lookup working signals
  // --------------------------------------------------------------------
  reg                        st_svc      [0:1];
  reg  [`OEMLH_EP_W-1:0]     st_idx      [0:1];
  reg  [`OEMLH_EP_W-1:0]     st_act      [0:1];
  reg                        st_go       [0:1];
  reg                        st_tx       [0:1];
  reg  [`OEMLH_EP_W-1:0]     mem_ep      [0:`OEMLH_MEMBERS-1];
  reg  [`OEMLH_MEMBERS-1:0]  mem_v;
  reg  [`OEMLH_MEMBERS-1:0]  mem_tx;
  reg  [`OEMLH_INC_W-1:0]    inc_rx      [0:`OEMLH_NUM_EP-1];
  reg  [`OEMLH_INC_W-1:0]    inc_tx      [0:`OEMLH_NUM_EP-1];
  reg  [`OEMLH_EP_W-1:0]     act;
  reg  [`OEMLH_EP_W-1:0]     srv;
  reg                        is_port;
  integer                    s;
  integer                    m;
  // every process owns its loop index, so each index has one driver
  integer                    i;
  integer                    r;
  integer                    c;
  integer                    k;

  // --------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------
  wire [3:0]                 blk   = paddr[11:8];
  wire [3:0]                 wi    = paddr[5:2];
  wire                       align = (paddr[7:6] == 2'b00) &&
                                     (paddr[1:0] == 2'b00);
  wire                       setup = psel && !penable;
  wire                       wr    = psel && penable && pwrite && align;
  reg  [31:0]                rd_d;
  reg                        err_d;

  // zero wait states: answer comes in the access cycle
  assign pready = 1'b1;

  // --------------------------------------------------------------------
  // stage selection of the active endpoint
  // --------------------------------------------------------------------
  // stage 0 is the analyzer, stage 1 the rewriter
  // a disabled mapped endpoint is not retried on the port endpoint
  always @* begin
    st_svc[0] = svc_ena_q[ana_service_index];
    st_idx[0] = svc_idx_q[ana_service_index];
    st_svc[1] = egress_endpoint_map_valid;
    st_idx[1] = egress_endpoint_index;
    for (s = 0; s < 2; s = s + 1) begin
      if (st_svc[s]) begin
        st_act[s] = st_idx[s];
      end else if (s == 0) begin
        st_act[s] = {1'b0, ana_port};
      end else begin
        st_act[s] = {1'b0, rew_port};
      end
      st_go[s] = ((s == 0) ? ana_valid : rew_valid) &&
                 ep_ena_q[st_act[s]];
      st_tx[s] = (s == 0) ? ep_up_q[st_act[s]] : !ep_up_q[st_act[s]];
    end
  end

  // --------------------------------------------------------------------
  // hierarchy members: active, server, resident port per stage
  // --------------------------------------------------------------------
  always @* begin
    act     = {`OEMLH_EP_W{1'b0}};
    srv     = {`OEMLH_EP_W{1'b0}};
    is_port = 1'b0;
    mem_v   = {`OEMLH_MEMBERS{1'b0}};
    mem_tx  = {`OEMLH_MEMBERS{1'b0}};
    for (m = 0; m < `OEMLH_MEMBERS; m = m + 1) begin
      mem_ep[m] = {`OEMLH_EP_W{1'b0}};
    end
    // members 0..2 belong to the analyzer, 3..5 to the rewriter
    // same hierarchy both stages
    for (m = 0; m < 2; m = m + 1) begin
      act     = st_act[m];
      srv     = link_id_q[act];
      is_port = (act < `OEMLH_NUM_PORT);
      mem_ep[3*m]   = act;
      mem_v[3*m]    = st_go[m];
      // server link setup
      // servers never chain on; a link to itself is ignored
      mem_ep[3*m+1] = srv;
      mem_v[3*m+1]  = st_go[m] && !is_port && !ep_srv_q[act] &&
                      link_ena_q[act] && ep_srv_q[srv] && (srv != act);
      mem_ep[3*m+2] = {1'b0, ep_port_q[act]};
      mem_v[3*m+2]  = st_go[m] && !is_port &&
                      !(ep_srv_q[act] && ep_up_q[act]);
      mem_tx[3*m]   = st_tx[m];
      mem_tx[3*m+1] = st_tx[m];
      mem_tx[3*m+2] = st_tx[m];
    end
  end

  // --------------------------------------------------------------------
  // per-endpoint increments from both stages
  // --------------------------------------------------------------------
  // both stages add up
  // up to four members may hit one endpoint, two per stage, hence three-bit sums
  always @* begin
    for (i = 0; i < `OEMLH_NUM_EP; i = i + 1) begin
      inc_rx[i] = {`OEMLH_INC_W{1'b0}};
      inc_tx[i] = {`OEMLH_INC_W{1'b0}};
      for (r = 0; r < `OEMLH_MEMBERS; r = r + 1) begin
        if (mem_v[r] && (mem_ep[r] == i[`OEMLH_EP_W-1:0])) begin
          if (mem_tx[r]) begin
            inc_tx[i] = inc_tx[i] + 3'h1;
          end else begin
            inc_rx[i] = inc_rx[i] + 3'h1;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // apb read mux, captured in the setup cycle
  // --------------------------------------------------------------------
  always @* begin
    rd_d  = 32'h00000000;
    err_d = !align;
    case (blk)
      `OEMLH_BLK_CTRL: begin
        rd_d[`OEMLH_CTRL_ENA] = ep_ena_q[wi];
        rd_d[`OEMLH_CTRL_UP]  = ep_up_q[wi];
        rd_d[`OEMLH_CTRL_SRV] = ep_srv_q[wi];
        rd_d[`OEMLH_CTRL_PORT+`OEMLH_PORT_W-1:`OEMLH_CTRL_PORT] =
          ep_port_q[wi];
      end
      `OEMLH_BLK_LINK: begin
        rd_d[`OEMLH_LINK_ENA] = link_ena_q[wi];
        rd_d[`OEMLH_LINK_ID+`OEMLH_EP_W-1:`OEMLH_LINK_ID] = link_id_q[wi];
      end
      `OEMLH_BLK_SVC: begin
        rd_d[`OEMLH_SVC_ENA] = svc_ena_q[wi];
        rd_d[`OEMLH_SVC_IDX+`OEMLH_EP_W-1:`OEMLH_SVC_IDX] = svc_idx_q[wi];
      end
      `OEMLH_BLK_CNT: begin
        rd_d[`OEMLH_CNT_W-1:0] = cnt_rx_q[wi];
        rd_d[`OEMLH_CNT_TX+`OEMLH_CNT_W-1:`OEMLH_CNT_TX] = cnt_tx_q[wi];
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
    if (err_d) begin
      rd_d = 32'h00000000;
    end
  end

  // holding at setup keeps the answer steady through the access phase
  // read data and error registered at setup, shown in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_d;
      pslverr <= err_d;
    end
  end

  // --------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep_ena_q   <= `OEMLH_RST_FLAGS;
      ep_up_q    <= `OEMLH_RST_FLAGS;
      ep_srv_q   <= `OEMLH_RST_FLAGS;
      link_ena_q <= `OEMLH_RST_FLAGS;
      svc_ena_q  <= `OEMLH_RST_FLAGS;
      for (c = 0; c < `OEMLH_NUM_EP; c = c + 1) begin
        ep_port_q[c] <= `OEMLH_RST_PORT;
        link_id_q[c] <= `OEMLH_RST_IDX;
        svc_idx_q[c] <= `OEMLH_RST_IDX;
      end
    end else if (wr) begin
      case (blk)
        `OEMLH_BLK_CTRL: begin
          ep_ena_q[wi]  <= pwdata[`OEMLH_CTRL_ENA];
          ep_up_q[wi]   <= pwdata[`OEMLH_CTRL_UP];
          ep_srv_q[wi]  <= pwdata[`OEMLH_CTRL_SRV];
          ep_port_q[wi] <=
            pwdata[`OEMLH_CTRL_PORT+`OEMLH_PORT_W-1:`OEMLH_CTRL_PORT];
        end
        `OEMLH_BLK_LINK: begin
          link_ena_q[wi] <= pwdata[`OEMLH_LINK_ENA];
          link_id_q[wi]  <=
            pwdata[`OEMLH_LINK_ID+`OEMLH_EP_W-1:`OEMLH_LINK_ID];
        end
        `OEMLH_BLK_SVC: begin
          svc_ena_q[wi] <= pwdata[`OEMLH_SVC_ENA];
          svc_idx_q[wi] <=
            pwdata[`OEMLH_SVC_IDX+`OEMLH_EP_W-1:`OEMLH_SVC_IDX];
        end
        default: begin
          // writes to other blocks are dropped
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // loss-measurement counters; a write clears, same-cycle counts survive
  // --------------------------------------------------------------------
  // one-cycle atomic commit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < `OEMLH_NUM_EP; k = k + 1) begin
        cnt_rx_q[k] <= `OEMLH_RST_CNT;
        cnt_tx_q[k] <= `OEMLH_RST_CNT;
      end
    end else begin
      for (k = 0; k < `OEMLH_NUM_EP; k = k + 1) begin
        // a clear keeps this cycle's increments so no frame is lost
        if (wr && (blk == `OEMLH_BLK_CNT) &&
            (wi == k[`OEMLH_EP_W-1:0])) begin
          cnt_rx_q[k] <= {13'h0000, inc_rx[k]};
          cnt_tx_q[k] <= {13'h0000, inc_tx[k]};
        end else begin
          cnt_rx_q[k] <= cnt_rx_q[k] + {13'h0000, inc_rx[k]};
          cnt_tx_q[k] <= cnt_tx_q[k] + {13'h0000, inc_tx[k]};
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // active endpoint outputs, one result per stage per frame
  // --------------------------------------------------------------------
  // user-to-network roles
  // network-to-user roles
  // ep and tx follow every cycle; they mean something only with valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_active_valid <= 1'b0;
      ana_active_ep    <= `OEMLH_RST_IDX;
      ana_active_tx    <= 1'b0;
      rew_active_valid <= 1'b0;
      rew_active_ep    <= `OEMLH_RST_IDX;
      rew_active_tx    <= 1'b0;
    end else begin
      ana_active_valid <= st_go[0];
      ana_active_ep    <= st_act[0];
      ana_active_tx    <= st_tx[0];
      rew_active_valid <= st_go[1];
      rew_active_ep    <= st_act[1];
      rew_active_tx    <= st_tx[1];
    end
  end

endmodule // oemlh_top

/* tb/oemlh_monitor.sv */
// checker: timing relations at the ports of the endpoint mapping block
// assumes one pclk domain and binding onto oemlh_top
`timescale 1ns/1ps
`include "oemlh_consts.vh"
module oemlh_monitor (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [`OEMLH_ADDR_W-1:0] paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  ana_valid,
  input wire logic                  ana_active_valid,
  input wire logic                  rew_valid,
  input wire logic [`OEMLH_PORT_W-1:0] rew_port,
  input wire logic                  egress_endpoint_map_valid,
  input wire logic [`OEMLH_EP_W-1:0] egress_endpoint_index,
  input wire logic                  rew_active_valid,
  input wire logic [`OEMLH_EP_W-1:0] rew_active_ep
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_ana_lat; ana_active_valid |-> $past(ana_valid); endproperty
  property p_rew_lat; rew_active_valid |-> $past(rew_valid); endproperty
  property p_rew_ep;
    rew_active_valid && $past(egress_endpoint_map_valid)
      |-> rew_active_ep == $past(egress_endpoint_index);
  endproperty
  property p_rew_port;
    rew_active_valid && !$past(egress_endpoint_map_valid)
      |-> rew_active_ep == {1'b0, $past(rew_port)};
  endproperty
  property p_slverr; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
  endproperty
  property p_wr_zero; psel && !penable && pwrite |=> prdata == 32'h0;
  endproperty
  property p_hold; psel && penable |=> $stable(prdata) && $stable(pslverr);
  endproperty
  property p_ready; psel && penable |-> pready; endproperty
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  // no result without a lookup one cycle before
  a_ana_lat: assert property (p_ana_lat)
    else $error("analyzer result without lookup");
  a_rew_lat: assert property (p_rew_lat)
    else $error("rewriter result without lookup");
  a_rew_ep: assert property (p_rew_ep)
    else $error("rewriter endpoint not the mapped index");
  a_rew_port: assert property (p_rew_port)
    else $error("rewriter endpoint not the port endpoint");
  a_slverr: assert property (p_slverr)
    else $error("misaligned access not refused");
  a_wr_zero: assert property (p_wr_zero)
    else $error("read data not zero on write");
  a_hold: assert property (p_hold)
    else $error("read answer changed before next setup");
  a_ready: assert property (p_ready)
    else $error("access phase without ready");
  c_ana: cover property (ana_active_valid);
  c_rew: cover property (rew_active_valid && egress_endpoint_map_valid);
  c_err: cover property (psel && penable && pslverr);
endmodule // oemlh_monitor

/* tb/oemlh_pipe_model.sv */
// model of the analyzer and rewriter lookup stages feeding the block
// assumes the bench calls its tasks; one frame per call
`timescale 1ns/1ps
module oemlh_pipe_model (
  input  wire logic       pclk,
  output logic            ana_valid,
  output logic [2:0]      ana_port,
  output logic [3:0]      ana_service_index,
  output logic            rew_valid,
  output logic [2:0]      rew_port,
  output logic            egress_endpoint_map_valid,
  output logic [3:0]      egress_endpoint_index
);
  // start: no lookup, lines hold a fixed pattern; after a frame they hold its complement
  initial begin
    ana_valid = 1'b0;
    ana_port = 3'h5;
    ana_service_index = 4'hA;
    rew_valid = 1'b0;
    rew_port = 3'h5;
    egress_endpoint_map_valid = 1'b0;
    egress_endpoint_index = 4'hA;
  end
  task automatic ana_frame(input logic [2:0] p, input logic [3:0] s);
    @(posedge pclk);
    ana_valid <= 1'b1;
    ana_port <= p;
    ana_service_index <= s;
    @(posedge pclk);
    ana_valid <= 1'b0;
    ana_port <= ~p;
    ana_service_index <= ~s;
  endtask
  task automatic rew_frame(input logic [2:0] p, input logic v,
                           input logic [3:0] i);
    @(posedge pclk);
    rew_valid <= 1'b1;
    rew_port <= p;
    egress_endpoint_map_valid <= v;
    egress_endpoint_index <= i;
    @(posedge pclk);
    rew_valid <= 1'b0;
    rew_port <= ~p;
    egress_endpoint_map_valid <= ~v;
    egress_endpoint_index <= ~i;
  endtask
endmodule // oemlh_pipe_model

/* tb/tb_oam_endpoint_mapping_lm_hierarchy.sv */
// bench: apb setup, lookups at both stages, counter checks
// assumes oemlh_top, oemlh_pipe_model and oemlh_monitor
`timescale 1ns/1ps
`include "oemlh_consts.vh"
module tb_oam_endpoint_mapping_lm_hierarchy;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        ana_valid, rew_valid, emv;
  logic [2:0]  ana_port, rew_port;
  logic [3:0]  ana_svc, eidx;
  logic        av, atx, rv, rtx;
  logic [3:0]  aep, rep;
  logic [15:0] erx [16] = '{default: 16'h0};
  logic [15:0] etx [16] = '{default: 16'h0};
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  // endpoint setup: ports 0 and 2, up pair 9/10, down pair 7/8
  localparam logic [11:0] CA [11] = '{12'h100, 12'h108, 12'h11C,
    12'h120, 12'h124, 12'h128, 12'h21C, 12'h224, 12'h30C, 12'h314, 12'h318};
  localparam logic [31:0] CD [11] = '{32'h01, 32'h21, 32'h21, 32'h25,
    32'h03, 32'h07, 32'h81, 32'hA1, 32'h91, 32'h71, 32'hA1};

  always #25 pclk = ~pclk;

  oemlh_pipe_model i_pipe (.pclk(pclk), .ana_valid(ana_valid),
    .ana_port(ana_port), .ana_service_index(ana_svc),
    .rew_valid(rew_valid), .rew_port(rew_port),
    .egress_endpoint_map_valid(emv), .egress_endpoint_index(eidx));

  oemlh_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ana_valid(ana_valid), .ana_port(ana_port), .ana_service_index(ana_svc),
    .rew_valid(rew_valid), .rew_port(rew_port),
    .egress_endpoint_map_valid(emv), .egress_endpoint_index(eidx),
    .ana_active_valid(av), .ana_active_ep(aep), .ana_active_tx(atx),
    .rew_active_valid(rv), .rew_active_ep(rep), .rew_active_tx(rtx));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask

  // one lookup, result check, expected counter fan-out over mem
  task automatic look(input logic rew, input logic [2:0] p,
      input logic [3:0] s, input logic mv, input logic v,
      input logic [3:0] ep, input logic tx, input logic [15:0] mem);
    if (rew) i_pipe.rew_frame(p, mv, s);
    else i_pipe.ana_frame(p, s);
    #1;
    chk({31'h0, rew ? rv : av}, {31'h0, v});
    if (v) chk({27'h0, rew ? {rtx, rep} : {atx, aep}}, {27'h0, tx, ep});
    for (int i = 0; i < 16; i++)
      if (mem[i]) begin
        if (tx) etx[i]++;
        else erx[i]++;
      end
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h124, 32'h0, 1'b0);
    for (int i = 0; i < 11; i++) wr(CA[i], CD[i]);
    for (int i = 0; i < 11; i++) rd(CA[i], CD[i], 1'b0);
    rd(12'h102, 32'h0, 1'b1);
    rd(12'h800, 32'h0, 1'b1);
    rd(12'h140, 32'h0, 1'b1);
    look(0, 0, 3, 0, 1, 9, 1, 16'h0601);
    look(1, 0, 9, 1, 1, 9, 0, 16'h0601);
    look(1, 2, 7, 1, 1, 7, 1, 16'h0184);
    look(0, 2, 5, 0, 1, 7, 0, 16'h0184);
    look(1, 2, 8, 1, 1, 8, 1, 16'h0104);
    look(0, 0, 6, 0, 1, 10, 1, 16'h0400);
    look(0, 2, 0, 0, 1, 2, 0, 16'h0004);
    look(1, 2, 4, 0, 1, 2, 1, 16'h0004);
    look(0, 1, 0, 0, 0, 0, 0, 16'h0000);
    wr(12'h424, 32'h0);
    erx[9] = 16'h0;
    etx[9] = 16'h0;
    look(0, 0, 3, 0, 1, 9, 1, 16'h0601);
    for (int i = 0; i < 16; i++)
      rd(12'(12'h400 + 4 * i), {etx[i], erx[i]}, 1'b0);
    wrap_up;
  end
endmodule // tb_oam_endpoint_mapping_lm_hierarchy

bind oemlh_top oemlh_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ana_valid(ana_valid), .ana_active_valid(ana_active_valid),
  .rew_valid(rew_valid), .rew_port(rew_port),
  .egress_endpoint_map_valid(egress_endpoint_map_valid),
  .egress_endpoint_index(egress_endpoint_index),
  .rew_active_valid(rew_active_valid), .rew_active_ep(rew_active_ep));
